// ---- verilog/quhbs_pkg.sv ----
// constants and types shared by the quad uart host bus front end
`default_nettype none
package quhbs_pkg;
    // -------------------------------------------------------------------
    // register indices inside one channel
    // -------------------------------------------------------------------
    localparam logic [2:0] QUHBS_IDX_IER = 3'h1;
    localparam logic [2:0] QUHBS_IDX_MCR = 3'h4;
    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int QUHBS_IER_RX_AVAIL = 0;
    localparam int QUHBS_IER_TX_EMPTY = 1;
    localparam int QUHBS_IER_RX_ERROR = 2;
    localparam int QUHBS_IER_MODEM = 3;
    localparam int QUHBS_MCR_IRQ_EN = 3;
    localparam int QUHBS_MCR_PRESCALE = 7;
    // -------------------------------------------------------------------
    // reset values and timing counts
    // -------------------------------------------------------------------
    localparam logic [7:0] QUHBS_IER_RESET = 8'h00;
    localparam logic [7:0] QUHBS_MCR_RESET = 8'h00;
    localparam logic [1:0] QUHBS_DIV4_LAST = 2'h3;
    localparam logic [1:0] QUHBS_DIV1_LAST = 2'h0;
    // -------------------------------------------------------------------
    // state records
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] irq_enable_reg;
        logic [7:0] modem_control_reg;
    } quhbs_chan_state_t;

    typedef struct packed {
        logic [7:0] dout;
        logic dout_oe;
        logic rd_q;
        logic wr_q;
        logic cs_q;
        logic [3:0] wr_p;
        logic [3:0] rd_p;
        logic [2:0] idx;
        logic [7:0] wdata;
        logic [3:0] irq;
        logic [3:0] irq_oe;
        logic irq_comb_oe;
        logic psc_ovr;
        logic psc_ovr_val;
        logic div4;
        logic [1:0] pcnt;
        logic tick;
        logic urst;
    } quhbs_state_t;
endpackage
`default_nettype wire

// ---- verilog/quhbs_chan_if.sv ----
// carrier between the bus front end and one channel register slice
`timescale 1ns/1ps
`default_nettype none
interface quhbs_chan_if;
    logic wr;
    logic clr;
    logic [2:0] idx;
    logic [7:0] wdata;
    logic [7:0] irq_enable_reg;
    logic [7:0] modem_control_reg;
    modport host (output wr, output clr, output idx, output wdata,
                  input irq_enable_reg, input modem_control_reg);
    modport chan (input wr, input clr, input idx, input wdata,
                  output irq_enable_reg, output modem_control_reg);
endinterface
`default_nettype wire

// ---- verilog/quhbs_chan_regs.sv ----
// interrupt enable and modem control storage of one channel
`timescale 1ns/1ps
`default_nettype none
module quhbs_chan_regs
    import quhbs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // front end side
    quhbs_chan_if.chan bus
);
    quhbs_chan_state_t st_reg;
    quhbs_chan_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (bus.clr)
        begin
            st_next.irq_enable_reg = QUHBS_IER_RESET;
            st_next.modem_control_reg = QUHBS_MCR_RESET;
        end
        else if (bus.wr)
        begin
            if (bus.idx == QUHBS_IDX_IER)
                st_next.irq_enable_reg = bus.wdata; // [RULE18]
            if (bus.idx == QUHBS_IDX_MCR)
                st_next.modem_control_reg = bus.wdata; // [RULE18]
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_reg <= '{irq_enable_reg: QUHBS_IER_RESET, modem_control_reg: QUHBS_MCR_RESET};
        else
            st_reg <= st_next;
    end

    assign bus.irq_enable_reg = st_reg.irq_enable_reg;
    assign bus.modem_control_reg = st_reg.modem_control_reg;
endmodule
`default_nettype wire

// ---- verilog/quhbs_top.sv ----
// parallel host port front end of a four channel uart
// Functional notes
// RULE1 - mode pin high picks 16, low 68
// RULE2 - unconnected mode pin defaults to 16 mode
// RULE3 - 68: write pin is direction, reset inverted
// RULE4 - 68: channel interrupts merged on one output
// RULE5 - three index bits pick the channel register
// RULE6 - 68: channel bits pick channel under select
// RULE7 - 16: channel bits become selects B and C
// RULE8 - 68: shared select low enables all channels
// RULE9 - 16: channel reached only by its select
// RULE10 - prescale pin high divides 1, low 4
// RULE11 - control bit 7 overrides prescale pin
// RULE12 - ready read drives inverted ready flags
// RULE13 - eight bit three state data bus
// RULE14 - 16: interrupt needs control bit 3, enable
// RULE15 - small package fixed to 16 mode
// RULE16 - drive select pin forces interrupt drive; code applies it in 16 mode only, 68 combined output ignores it
// RULE17 - 16: read falling edge outputs register
// RULE18 - 16: write falling edge loads register
// RULE19 - four sources raise a channel interrupt
// RULE20 - 68: direction sampled at select falling
`timescale 1ns/1ps
`default_nettype none
module quhbs_top
    import quhbs_pkg::*;
#(
    parameter bit SMALL_PKG = 1'b0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // mode and option pins
    input wire logic bus_mode_pin,
    input wire logic bus_mode_pin_connected,
    input wire logic prescale_select_pin,
    input wire logic irq_drive_select,
    input wire logic uart_reset_pin,
    // host strobes and address
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_d_n,
    input wire logic [1:0] channel_index_bits,
    input wire logic reg_index_bit0,
    input wire logic reg_index_bit1,
    input wire logic reg_index_bit2,
    input wire logic ready_summary_read_n,
    // host data bus
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    // interrupt pins
    output logic [3:0] irq_out,
    output logic [3:0] irq_oe,
    output logic irq_comb_out,
    output logic irq_comb_oe,
    // channel core side
    input wire logic [3:0] tx_ready_flag,
    input wire logic [3:0] rx_ready_flag,
    input wire logic [3:0] rx_data_avail,
    input wire logic [3:0] tx_buf_empty,
    input wire logic [3:0] rx_error,
    input wire logic [3:0] modem_change,
    input wire logic [31:0] core_rd_data,
    output logic [3:0] core_wr_pulse,
    output logic [3:0] core_rd_pulse,
    output logic [2:0] core_index,
    output logic [7:0] core_wdata,
    output logic prescale_div4,
    output logic baud_tick,
    output logic uart_reset
);
    // -------------------------------------------------------------------
    // selection helpers
    // -------------------------------------------------------------------
    function automatic logic [3:0] chan_sel(input logic m16,
        input logic cs_a_n, input logic [1:0] ci, input logic cs_d_n);
        logic [3:0] s;
        s = 4'h0;
        if (m16)
            s = ~{cs_d_n, ci[1], ci[0], cs_a_n}; // [RULE7] [RULE9]
        else if (!cs_a_n)
            s[ci] = 1'b1; // [RULE6] [RULE8]
        return s;
    endfunction

    function automatic logic [7:0] reg_value(input logic [2:0] ix,
        input logic [7:0] irq_enable_reg, input logic [7:0] modem_control_reg,
        input logic [7:0] core);
        logic [7:0] v;
        v = core;
        if (ix == QUHBS_IDX_IER)
            v = irq_enable_reg;
        else if (ix == QUHBS_IDX_MCR)
            v = modem_control_reg;
        return v;
    endfunction

    // -------------------------------------------------------------------
    // channel register slices
    // -------------------------------------------------------------------
    quhbs_state_t st_reg;
    quhbs_state_t st_next;
    quhbs_chan_if ch_if[4] ();
    logic [7:0] ier_w [4];
    logic [7:0] mcr_w [4];

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_chan
            assign ch_if[g].wr = st_reg.wr_p[g];
            assign ch_if[g].clr = st_reg.urst;
            assign ch_if[g].idx = st_reg.idx;
            assign ch_if[g].wdata = st_reg.wdata;
            assign ier_w[g] = ch_if[g].irq_enable_reg;
            assign mcr_w[g] = ch_if[g].modem_control_reg;
            quhbs_chan_regs u_regs (
                .clk(clk),
                .rstn(rstn),
                .bus(ch_if[g].chan)
            );
        end
    endgenerate

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    logic mode16;
    logic [2:0] ridx;
    logic [3:0] sel;
    logic [3:0] cond;
    logic [7:0] rsel;
    logic rd_fall;
    logic wr_fall;
    logic cs_fall;

    always_comb
    begin
        // missing pin or small package falls back to 16 mode
        mode16 = SMALL_PKG | ~bus_mode_pin_connected
                 | bus_mode_pin; // [RULE1] [RULE2] [RULE15]
        ridx = {reg_index_bit2, reg_index_bit1, reg_index_bit0}; // [RULE5]
        sel = chan_sel(mode16, chip_select_a_n, channel_index_bits,
                       chip_select_d_n);
        rd_fall = st_reg.rd_q & ~read_strobe_n;
        wr_fall = st_reg.wr_q & ~write_strobe_n;
        cs_fall = st_reg.cs_q & ~chip_select_a_n;
        rsel = 8'h00;
        cond = 4'h0;
        for (int i = 3; i >= 0; i--)
        begin
            if (sel[i])
                rsel = reg_value(ridx, ier_w[i], mcr_w[i],
                                 core_rd_data[8*i +: 8]);
            cond[i] = (ier_w[i][QUHBS_IER_RX_AVAIL] & rx_data_avail[i])
                | (ier_w[i][QUHBS_IER_TX_EMPTY] & tx_buf_empty[i])
                | (ier_w[i][QUHBS_IER_RX_ERROR] & rx_error[i])
                | (ier_w[i][QUHBS_IER_MODEM] & modem_change[i]); // [RULE19]
        end

        st_next = st_reg;
        st_next.rd_q = read_strobe_n;
        st_next.wr_q = write_strobe_n;
        st_next.cs_q = chip_select_a_n;
        st_next.wr_p = 4'h0;
        st_next.rd_p = 4'h0;
        // reset pin polarity flips with the bus style
        st_next.urst = mode16 ? uart_reset_pin : ~uart_reset_pin; // [RULE3]

        if (mode16)
        begin
            if (rd_fall && (sel != 4'h0))
            begin
                st_next.dout = rsel; // [RULE17]
                st_next.dout_oe = 1'b1;
                st_next.rd_p = sel;
                st_next.idx = ridx;
            end
            else if (read_strobe_n)
                st_next.dout_oe = 1'b0;
            if (wr_fall && (sel != 4'h0))
            begin
                st_next.wr_p = sel; // [RULE18] [RULE9]
                st_next.idx = ridx;
                st_next.wdata = host_data_bus_in;
            end
        end
        else
        begin
            // read strobe ignored; direction taken at select edge
            if (cs_fall)
            begin
                st_next.idx = ridx;
                if (write_strobe_n)
                begin
                    st_next.dout = rsel; // [RULE20] [RULE3]
                    st_next.dout_oe = 1'b1;
                    st_next.rd_p = sel;
                end
                else
                begin
                    st_next.wr_p = sel; // [RULE20] [RULE6]
                    st_next.wdata = host_data_bus_in;
                end
            end
            else if (chip_select_a_n)
                st_next.dout_oe = 1'b0;
        end

        // ready summary read takes the bus over any register read
        if (!ready_summary_read_n)
        begin
            st_next.dout = {~rx_ready_flag, ~tx_ready_flag}; // [RULE12]
            st_next.dout_oe = 1'b1; // [RULE13]
        end
        else if (!st_reg.rd_q && !st_reg.dout_oe && !read_strobe_n)
            st_next.dout_oe = 1'b0;

        // interrupt pins
        if (mode16)
        begin
            st_next.irq = cond; // [RULE14]
            for (int i = 0; i < 4; i++)
                st_next.irq_oe[i] = irq_drive_select
                    | mcr_w[i][QUHBS_MCR_IRQ_EN]; // [RULE16] [RULE14]
            st_next.irq_comb_oe = 1'b0;
        end
        else
        begin
            st_next.irq = 4'h0;
            st_next.irq_oe = 4'h0;
            st_next.irq_comb_oe = |cond; // [RULE4]
        end

        // prescale: last control write wins over the pin until reset
        if (st_reg.urst)
            st_next.psc_ovr = 1'b0;
        else
            for (int i = 0; i < 4; i++)
                if (st_reg.wr_p[i] && st_reg.idx == QUHBS_IDX_MCR)
                begin
                    st_next.psc_ovr = 1'b1; // [RULE11]
                    st_next.psc_ovr_val = st_reg.wdata[QUHBS_MCR_PRESCALE];
                end
        st_next.div4 = st_reg.psc_ovr ? st_reg.psc_ovr_val
                       : ~prescale_select_pin; // [RULE10] [RULE11]
        if (st_reg.pcnt >= (st_reg.div4 ? QUHBS_DIV4_LAST : QUHBS_DIV1_LAST))
        begin
            st_next.pcnt = 2'h0;
            st_next.tick = 1'b1; // [RULE10]
        end
        else
        begin
            st_next.pcnt = st_reg.pcnt + 2'h1;
            st_next.tick = 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
            st_reg.rd_q <= 1'b1;
            st_reg.wr_q <= 1'b1;
            st_reg.cs_q <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    assign host_data_bus_out = st_reg.dout;
    assign host_data_bus_oe = st_reg.dout_oe;
    assign irq_out = st_reg.irq;
    assign irq_oe = st_reg.irq_oe;
    assign irq_comb_out = 1'b0;
    assign irq_comb_oe = st_reg.irq_comb_oe;
    assign core_wr_pulse = st_reg.wr_p;
    assign core_rd_pulse = st_reg.rd_p;
    assign core_index = st_reg.idx;
    assign core_wdata = st_reg.wdata;
    assign prescale_div4 = st_reg.div4;
    assign baud_tick = st_reg.tick;
    assign uart_reset = st_reg.urst;
endmodule
`default_nettype wire

// ---- sim/quhbs_props.sv ----
// concurrent checks on the host bus front end ports
`timescale 1ns/1ps
`default_nettype none
module quhbs_props
    import quhbs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // mode and option pins
    input wire logic bus_mode_pin,
    input wire logic bus_mode_pin_connected,
    input wire logic prescale_select_pin,
    input wire logic irq_drive_select,
    input wire logic uart_reset_pin,
    // host strobes and address
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_d_n,
    input wire logic [1:0] channel_index_bits,
    input wire logic reg_index_bit0,
    input wire logic reg_index_bit1,
    input wire logic reg_index_bit2,
    input wire logic ready_summary_read_n,
    input wire logic [3:0] tx_ready_flag,
    input wire logic [3:0] rx_ready_flag,
    // device outputs
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    input wire logic [3:0] irq_oe,
    input wire logic irq_comb_out,
    input wire logic irq_comb_oe,
    input wire logic [3:0] core_wr_pulse,
    input wire logic [3:0] core_rd_pulse,
    input wire logic [2:0] core_index,
    input wire logic [7:0] core_wdata,
    input wire logic prescale_div4,
    input wire logic baud_tick,
    input wire logic uart_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic m68;
    logic [2:0] ridx;
    logic ovr_reg;
    logic ovr_val_reg;
    assign m68 = !bus_mode_pin && bus_mode_pin_connected;
    assign ridx = {reg_index_bit2, reg_index_bit1, reg_index_bit0};
    // mirror of the global prescale override, cleared by channel reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ovr_reg <= 1'b0;
            ovr_val_reg <= 1'b0;
        end
        else if (uart_reset)
            ovr_reg <= 1'b0;
        else if (|core_wr_pulse && core_index == QUHBS_IDX_MCR)
        begin
            ovr_reg <= 1'b1;
            ovr_val_reg <= core_wdata[QUHBS_MCR_PRESCALE];
        end
    end
    sequence s_only_a;
        !chip_select_a_n && chip_select_d_n && &channel_index_bits;
    endsequence
    sequence s_take68;
        m68 ##1 m68 && $fell(chip_select_a_n);
    endsequence
    // tick on a settled divide by 4, with the divider held two more cycles
    sequence s_div4_tick;
        $past(prescale_div4) && prescale_div4 && baud_tick
        ##1 prescale_div4 [*2];
    endsequence
    chk_wr16_take: assert property (
        !m68 && $fell(write_strobe_n) ##0 s_only_a
        |=> core_wr_pulse == 4'h1 && core_index == $past(ridx))
        else $error("16 write did not reach channel a");
    chk_rd16_drive: assert property (
        !m68 && $fell(read_strobe_n) && ready_summary_read_n ##0 s_only_a
        |=> host_data_bus_oe)
        else $error("16 read did not drive the bus");
    chk_rd16_pulse: assert property (
        !m68 && $fell(read_strobe_n) ##0 s_only_a
        |=> core_rd_pulse == 4'h1)
        else $error("16 read did not pulse channel a");
    chk_sel68_chan: assert property (
        s_take68 ##0 !write_strobe_n
        |=> core_wr_pulse == 4'h1 << $past(channel_index_bits))
        else $error("68 write went to the wrong channel");
    chk_rd68_ignore: assert property (
        m68 && chip_select_a_n && $past(chip_select_a_n)
        && $fell(read_strobe_n) && ready_summary_read_n
        |=> !host_data_bus_oe)
        else $error("read strobe acted in 68 mode");
    chk_ready_sum: assert property (
        (!ready_summary_read_n && $stable({rx_ready_flag, tx_ready_flag}))[*2]
        |-> host_data_bus_oe
        && host_data_bus_out == ~{rx_ready_flag, tx_ready_flag})
        else $error("ready summary wrong");
    chk_psc_pin: assert property (
        (!ovr_reg && $stable(prescale_select_pin))[*3]
        |-> prescale_div4 == !prescale_select_pin)
        else $error("prescale does not follow its pin");
    chk_psc_ovr: assert property (
        (ovr_reg && $stable(ovr_val_reg))[*3]
        |-> prescale_div4 == ovr_val_reg)
        else $error("prescale override ignored");
    chk_tick_div4: assert property (
        s_div4_tick |=> !baud_tick && !$past(baud_tick)
        && !$past(baud_tick, 2))
        else $error("divide by 4 tick too early");
    chk_irq68_off: assert property (
        m68 [*2] |-> irq_oe == 4'h0)
        else $error("channel interrupt driven in 68 mode");
    chk_irq16_comb: assert property (
        !m68 [*2] |-> !irq_comb_oe && !irq_comb_out)
        else $error("combined interrupt active in 16 mode");
    chk_irq_force: assert property (
        (!m68 && irq_drive_select)[*2] |-> irq_oe == 4'hF)
        else $error("drive select did not force interrupt drive");
    chk_rst_polar: assert property (
        ($stable(m68) && $stable(uart_reset_pin))[*2]
        |-> uart_reset == (uart_reset_pin ^ m68))
        else $error("channel reset polarity wrong");
endmodule
bind quhbs_top quhbs_props u_props (.*);
`default_nettype wire

// ---- sim/quhbs_host_model.sv ----
// host cpu model driving the parallel bus pins in either style
`timescale 1ns/1ps
`default_nettype none
module quhbs_host_model
(
    // clock
    input wire logic clk,
    // device answer
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    // host strobes, selects and address
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic chip_select_a_n,
    output logic chip_select_d_n,
    output logic [1:0] channel_index_bits,
    output logic reg_index_bit0,
    output logic reg_index_bit1,
    output logic reg_index_bit2,
    output logic [7:0] host_data_bus_in
);
    logic [7:0] drv = 8'h5A;
    // device drive wins; idle host bus shows the inverse of its last byte
    assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : drv;
    initial
    begin
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_a_n = 1'b1;
        chip_select_d_n = 1'b1;
        channel_index_bits = 2'h3;
        {reg_index_bit2, reg_index_bit1, reg_index_bit0} = 3'h0;
    end
    task automatic acc(input bit sty68, input bit wr, input logic [1:0] ch,
        input logic [2:0] idx, input logic [7:0] wd,
        output logic [7:0] rd, output logic oe);
        @(posedge clk);
        #1;
        {reg_index_bit2, reg_index_bit1, reg_index_bit0} = idx;
        drv = wr ? wd : drv;
        if (sty68)
        begin
            write_strobe_n = !wr;
            channel_index_bits = ch;
            @(posedge clk);
            #1;
            chip_select_a_n = 1'b0;
        end
        else
        begin
            // bit order: a, b, c, d selects
            {chip_select_d_n, channel_index_bits, chip_select_a_n} =
                ~(4'h1 << ch);
            @(posedge clk);
            #1;
            write_strobe_n = !wr;
            read_strobe_n = wr;
        end
        repeat (2) @(posedge clk);
        #1;
        rd = host_data_bus_out;
        oe = host_data_bus_oe;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_a_n = 1'b1;
        chip_select_d_n = 1'b1;
        channel_index_bits = 2'h3;
        drv = ~drv;
        repeat (2) @(posedge clk);
        // hand back off the edge so the caller never races the sampling edge
        #1;
    endtask
endmodule
`default_nettype wire

// ---- sim/quhbs_top_tb.sv ----
// self-checking bench for the quad uart host bus front end
`timescale 1ns/1ps
`default_nettype none
module quhbs_top_tb;
    import quhbs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic bus_mode_pin = 1'b1;
    logic bus_mode_pin_connected = 1'b1;
    logic prescale_select_pin = 1'b1;
    logic irq_drive_select = 1'b0;
    logic uart_reset_pin = 1'b0;
    logic ready_summary_read_n = 1'b1;
    logic [3:0] tx_ready_flag = 4'h0;
    logic [3:0] rx_ready_flag = 4'h0;
    logic [3:0] rx_data_avail = 4'h0;
    logic [3:0] tx_buf_empty = 4'h0;
    logic [3:0] rx_error = 4'h0;
    logic [3:0] modem_change = 4'h0;
    logic [31:0] core_rd_data = 32'h44332211;
    wire logic read_strobe_n, write_strobe_n, chip_select_a_n;
    wire logic chip_select_d_n, reg_index_bit0, reg_index_bit1;
    wire logic reg_index_bit2, host_data_bus_oe, irq_comb_out;
    wire logic irq_comb_oe, prescale_div4, baud_tick, uart_reset;
    wire logic [1:0] channel_index_bits;
    wire logic [7:0] host_data_bus_in, host_data_bus_out, core_wdata;
    wire logic [3:0] irq_out, irq_oe, core_wr_pulse, core_rd_pulse;
    wire logic [2:0] core_index;
    logic [7:0] rd;
    logic oe;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    quhbs_top u_dut (.*);
    quhbs_host_model u_host (.*);
    always #5 clk = ~clk;
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            finish_test();
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial
    begin
        cyc(8);
        rstn = 1'b1;
        cyc(4);
        cmp(8'(prescale_div4), 8'h0);
        prescale_select_pin = 1'b0;
        cyc(4);
        cmp(8'(prescale_div4), 8'h1);
        prescale_select_pin = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            u_host.acc(0, 1, c[1:0], QUHBS_IDX_MCR, 8'h88, rd, oe);
            u_host.acc(0, 1, c[1:0], QUHBS_IDX_IER, 8'(1 << c),
                       rd, oe);
        end
        cmp(8'(prescale_div4), 8'h1);
        for (int c = 0; c < 4; c++)
        begin
            u_host.acc(0, 0, c[1:0], QUHBS_IDX_IER, 8'h0, rd, oe);
            cmp(rd, 8'(1 << c));
            cmp(8'(oe), 8'h1);
            u_host.acc(0, 0, c[1:0], 3'h0, 8'h0, rd, oe);
            cmp(rd, core_rd_data[8*c +: 8]);
        end
        // each channel enables exactly one source kind
        for (int k = 0; k < 4; k++)
        begin
            {modem_change, rx_error, tx_buf_empty, rx_data_avail} =
                16'hF << (4 * k);
            cyc(3);
            cmp(8'(irq_out), 8'(1 << k));
            cmp(8'(irq_oe), 8'hF);
        end
        u_host.acc(0, 1, 2'h1, QUHBS_IDX_MCR, 8'h80, rd, oe);
        cmp(8'(irq_oe), 8'hD);
        irq_drive_select = 1'b1;
        cyc(3);
        cmp(8'(irq_oe), 8'hF);
        tx_ready_flag = 4'h5;
        rx_ready_flag = 4'hC;
        ready_summary_read_n = 1'b0;
        cyc(3);
        cmp(host_data_bus_out, 8'h3A);
        ready_summary_read_n = 1'b1;
        // 68 style: reset pin turns active low together with the mode
        uart_reset_pin = 1'b1;
        bus_mode_pin = 1'b0;
        cyc(3);
        cmp(8'(uart_reset), 8'h0);
        for (int c = 0; c < 4; c++)
            u_host.acc(1, 1, c[1:0], QUHBS_IDX_IER, 8'(c + 4),
                       rd, oe);
        for (int c = 0; c < 4; c++)
        begin
            u_host.acc(1, 0, c[1:0], QUHBS_IDX_IER, 8'h0, rd, oe);
            cmp(rd, 8'(c + 4));
        end
        cmp(8'(irq_comb_oe), 8'h0);
        rx_error = 4'h2;
        cyc(3);
        cmp(8'(irq_comb_oe), 8'h1);
        cmp(8'(irq_oe), 8'h0);
        u_host.acc(0, 0, 2'h3, 3'h0, 8'h0, rd, oe);
        cmp(8'(oe), 8'h0);
        uart_reset_pin = 1'b0;
        cyc(3);
        cmp(8'(uart_reset), 8'h1);
        uart_reset_pin = 1'b1;
        cyc(4);
        cmp(8'(prescale_div4), 8'h0);
        // open mode pin falls back to 16 style
        bus_mode_pin_connected = 1'b0;
        uart_reset_pin = 1'b0;
        cyc(3);
        u_host.acc(0, 0, 2'h2, 3'h0, 8'h0, rd, oe);
        cmp(rd, 8'h33);
        cmp(8'(uart_reset), 8'h0);
        finish_test();
    end
endmodule
`default_nettype wire
